// [core/ulfmc_baud.sv]
`timescale 1ns/1ps
`default_nettype none
module ulfmc_baud (
  input wire logic core_clk,
  input wire logic rst_n,
  ulfmc_baud_if.gen bd
);
  import ulfmc_pkg::*;

  typedef struct packed {
    logic [1:0] pre;
    logic [15:0] cnt;
    logic tick;
  } ulfmc_bd_t;

  ulfmc_bd_t s_r;
  ulfmc_bd_t s_nxt;
  logic [15:0] lastCnt;
  logic preEn;

  // ****************************************
  // prescale and divisor
  // ****************************************
  always_comb begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    lastCnt = (bd.divisor == 16'h0000) ? 16'h0000 : bd.divisor - 16'h0001;
    preEn = !bd.quarter || (s_r.pre == PRE_LAST);
    s_nxt.pre = bd.quarter ? s_r.pre + 2'h1 : 2'h0;
    if (preEn) begin
      if (s_r.cnt >= lastCnt) begin
        s_nxt.cnt = 16'h0000;
        s_nxt.tick = 1'b1;
      end else begin
        s_nxt.cnt = s_r.cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign bd.tick = s_r.tick;

  quarter_rate_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    bd.quarter && $stable(bd.quarter) && bd.divisor == 16'h0001 && s_r.tick
    |=> !s_r.tick [*3])
    else $error("tick faster than quarter rate");
  full_rate_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !bd.quarter && $past(!bd.quarter) && bd.divisor == 16'h0001
    && $past(bd.divisor) == 16'h0001 |-> ##1 s_r.tick)
    else $error("undivided clock lost ticks");

endmodule
`default_nettype wire

// [core/ulfmc_baud_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface ulfmc_baud_if;
  logic quarter;
  logic [15:0] divisor;
  logic tick;
  modport gen (input quarter, input divisor, output tick);
  modport user (output quarter, output divisor, input tick);
endinterface
`default_nettype wire

// [core/ulfmc_pkg.sv]
package ulfmc_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [2:0] ADDR_DATA = 3'h0;
  localparam logic [2:0] ADDR_DIVHI = 3'h1;
  localparam logic [2:0] ADDR_STAT = 3'h2;
  localparam logic [2:0] ADDR_LCR = 3'h3;
  localparam logic [2:0] ADDR_MCR = 3'h4;
  localparam logic [7:0] LCR_RST = 8'h00;
  localparam logic [7:0] MCR_RST = 8'h00;
  localparam logic [7:0] DIV_LO_RST = 8'h01;
  localparam logic [7:0] DIV_HI_RST = 8'h00;
  localparam logic [7:0] EFR_RST = 8'h00;
  localparam int LCR_DLAB = 7;
  localparam int LCR_BRK = 6;
  localparam int LCR_STOP = 2;
  localparam int MCR_QUAD = 7;
  localparam int MCR_IR = 6;
  localparam int ST_RXRDY = 0;
  localparam int ST_PERR = 1;
  localparam int ST_FERR = 2;
  localparam int ST_TXBUSY = 3;

  // ****************************************
  // timing
  // ****************************************
  localparam logic [4:0] OVS = 5'h10;
  localparam logic [4:0] MID = 5'h07;
  localparam logic [4:0] IR_PULSE = 5'h03;
  localparam logic [1:0] PRE_LAST = 2'h3;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_START = 3'b001,
    TX_DATA = 3'b010,
    TX_PAR = 3'b011,
    TX_STOP = 3'b100
  } ulfmc_tx_t;

  // ****************************************
  // shared arithmetic
  // ****************************************
  function automatic logic [7:0] dataMask(input logic [1:0] wlen);
    dataMask = 8'hFF >> (2'h3 - wlen);
  endfunction

  function automatic logic parBit(input logic [7:0] d,
                                  input logic [1:0] wlen,
                                  input logic [2:0] par);
    logic x;
    x = ^(d & dataMask(wlen));
    case (par[2:1])
      2'b00: parBit = ~x;
      2'b01: parBit = x;
      2'b10: parBit = 1'b1;
      default: parBit = 1'b0;
    endcase
  endfunction

  function automatic logic [5:0] stopTicks(input logic stop,
                                           input logic [1:0] wlen);
    if (!stop) begin
      stopTicks = 6'h10;
    end else if (wlen == 2'b00) begin
      stopTicks = 6'h18;
    end else begin
      stopTicks = 6'h20;
    end
  endfunction

endpackage

// [core/ulfmc_top.sv]
// Design decisions made here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module ulfmc_top (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  input wire logic serialIn,
  output logic serialOut,
  output logic [7:0] enhancedCfg
);
  import ulfmc_pkg::*;

  typedef struct packed {
    logic [7:0] line_format_control;
    logic [7:0] modem_interface_control;
    logic [7:0] divLo;
    logic [7:0] divHi;
    logic [7:0] efr;
    ulfmc_tx_t txSt;
    logic [7:0] txSh;
    logic [7:0] txByte;
    logic [2:0] txBit;
    logic [5:0] txTk;
    logic txLine;
    logic out;
    ulfmc_tx_t rxSt;
    logic [7:0] rxSh;
    logic [2:0] rxBit;
    logic [4:0] rxTk;
    logic [4:0] irHold;
    logic [7:0] rxData;
    logic rxRdy;
    logic pErr;
    logic fErr;
    logic [7:0] rdData;
  } ulfmc_st_t;

  ulfmc_st_t s_r;
  ulfmc_st_t s_nxt;
  ulfmc_baud_if bdIf ();
  logic tick;
  logic [1:0] wlen;
  logic [2:0] par;
  logic dlab;
  logic irOn;
  logic rxLine;
  logic rxRdySet;
  logic pErrSet;
  logic fErrSet;
  logic [7:0] stat;

  ulfmc_baud u_baud (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .bd(bdIf.gen)
  );

  assign bdIf.quarter = s_r.modem_interface_control[MCR_QUAD];
  assign bdIf.divisor = {s_r.divHi, s_r.divLo};
  assign tick = bdIf.tick;
  assign wlen = s_r.line_format_control[1:0];
  assign par = s_r.line_format_control[5:3];
  assign dlab = s_r.line_format_control[LCR_DLAB];
  assign irOn = s_r.modem_interface_control[MCR_IR];
  // decoded receive line, IR pulse marks a zero bit
  assign rxLine = irOn ? (s_r.irHold == 5'h00) : serialIn;

  always_comb begin
    s_nxt = s_r;
    rxRdySet = 1'b0;
    pErrSet = 1'b0;
    fErrSet = 1'b0;
    stat = {4'h0, s_r.txSt != TX_IDLE, s_r.fErr, s_r.pErr, s_r.rxRdy};

    // ****************************************
    // transmitter
    // ****************************************
    if (tick) begin
      case (s_r.txSt)
        TX_IDLE: begin
          s_nxt.txLine = 1'b1;
        end
        TX_START: begin
          s_nxt.txTk = s_r.txTk + 6'h01;
          if (s_r.txTk == {1'b0, OVS} - 6'h01) begin
            s_nxt.txTk = 6'h00;
            s_nxt.txSt = TX_DATA;
            s_nxt.txLine = s_r.txSh[0];
          end
        end
        TX_DATA: begin
          s_nxt.txTk = s_r.txTk + 6'h01;
          if (s_r.txTk == {1'b0, OVS} - 6'h01) begin
            s_nxt.txTk = 6'h00;
            s_nxt.txSh = s_r.txSh >> 1;
            s_nxt.txBit = s_r.txBit + 3'h1;
            if (s_r.txBit == {1'b0, wlen} + 3'h4) begin
              s_nxt.txBit = 3'h0;
              if (par[0]) begin
                s_nxt.txSt = TX_PAR;
                s_nxt.txLine = parBit(s_r.txByte, wlen, par);
              end else begin
                s_nxt.txSt = TX_STOP;
                s_nxt.txLine = 1'b1;
              end
            end else begin
              s_nxt.txLine = s_r.txSh[1];
            end
          end
        end
        TX_PAR: begin
          s_nxt.txTk = s_r.txTk + 6'h01;
          if (s_r.txTk == {1'b0, OVS} - 6'h01) begin
            s_nxt.txTk = 6'h00;
            s_nxt.txSt = TX_STOP;
            s_nxt.txLine = 1'b1;
          end
        end
        default: begin
          s_nxt.txTk = s_r.txTk + 6'h01;
          if (s_r.txTk == stopTicks(s_r.line_format_control[LCR_STOP], wlen) - 6'h01) begin
            s_nxt.txTk = 6'h00;
            s_nxt.txSt = TX_IDLE;
          end
        end
      endcase
    end
    if (regWr && regAddr == ADDR_DATA && !dlab && s_r.txSt == TX_IDLE) begin
      s_nxt.txSt = TX_START;
      s_nxt.txSh = regWrData;
      s_nxt.txByte = regWrData;
      s_nxt.txTk = 6'h00;
      s_nxt.txBit = 3'h0;
      s_nxt.txLine = 1'b0;
    end
    // pin driver: break first, then IR pulse or plain level
    if (s_r.line_format_control[LCR_BRK]) begin
      s_nxt.out = 1'b0;
    end else if (irOn) begin
      s_nxt.out = !s_r.txLine && s_r.txSt != TX_IDLE
                  && s_r.txTk[4:0] < IR_PULSE;
    end else begin
      s_nxt.out = s_r.txLine;
    end

    // ****************************************
    // receiver
    // ****************************************
    if (irOn && serialIn) begin
      s_nxt.irHold = OVS;
    end else if (tick && s_r.irHold != 5'h00) begin
      s_nxt.irHold = s_r.irHold - 5'h01;
    end
    if (tick) begin
      s_nxt.rxTk = s_r.rxTk + 5'h01;
      case (s_r.rxSt)
        TX_IDLE: begin
          s_nxt.rxTk = 5'h00;
          if (!rxLine) begin
            s_nxt.rxSt = TX_START;
          end
        end
        TX_START: begin
          if (s_r.rxTk == MID) begin
            s_nxt.rxTk = 5'h00;
            s_nxt.rxBit = 3'h0;
            s_nxt.rxSh = 8'h00;
            s_nxt.rxSt = rxLine ? TX_IDLE : TX_DATA;
          end
        end
        TX_DATA: begin
          if (s_r.rxTk == OVS - 5'h01) begin
            s_nxt.rxTk = 5'h00;
            s_nxt.rxSh = (s_r.rxSh >> 1) | {rxLine, 7'h00};
            s_nxt.rxBit = s_r.rxBit + 3'h1;
            if (s_r.rxBit == {1'b0, wlen} + 3'h4) begin
              s_nxt.rxSh = ((s_r.rxSh >> 1) | {rxLine, 7'h00})
                           >> (2'h3 - wlen);
              s_nxt.rxSt = par[0] ? TX_PAR : TX_STOP;
            end
          end
        end
        TX_PAR: begin
          if (s_r.rxTk == OVS - 5'h01) begin
            s_nxt.rxTk = 5'h00;
            s_nxt.rxSt = TX_STOP;
            pErrSet = rxLine != parBit(s_r.rxSh, wlen, par);
          end
        end
        default: begin
          if (s_r.rxTk == OVS - 5'h01) begin
            s_nxt.rxTk = 5'h00;
            s_nxt.rxSt = TX_IDLE;
            s_nxt.rxData = s_r.rxSh;
            rxRdySet = 1'b1;
            fErrSet = !rxLine;
          end
        end
      endcase
    end

    // ****************************************
    // register port
    // ****************************************
    s_nxt.rdData = 8'h00;
    if (regWr) begin
      if (regAddr == ADDR_LCR) begin
        s_nxt.line_format_control = regWrData;
      end else if (regAddr == ADDR_MCR) begin
        s_nxt.modem_interface_control = regWrData;
      end else if (regAddr == ADDR_DATA && dlab) begin
        s_nxt.divLo = regWrData;
      end else if (regAddr == ADDR_DIVHI && dlab) begin
        s_nxt.divHi = regWrData;
      end else if (regAddr == ADDR_STAT && dlab) begin
        s_nxt.efr = regWrData;
      end
    end
    if (regRd) begin
      if (regAddr == ADDR_LCR) begin
        s_nxt.rdData = s_r.line_format_control;
      end else if (regAddr == ADDR_MCR) begin
        s_nxt.rdData = s_r.modem_interface_control;
      end else if (regAddr == ADDR_DATA) begin
        s_nxt.rdData = dlab ? s_r.divLo : s_r.rxData;
      end else if (regAddr == ADDR_DIVHI && dlab) begin
        s_nxt.rdData = s_r.divHi;
      end else if (regAddr == ADDR_STAT) begin
        s_nxt.rdData = dlab ? s_r.efr : stat;
      end
    end
    // set wins over read clear
    if (regRd && regAddr == ADDR_DATA && !dlab) begin
      s_nxt.rxRdy = 1'b0;
    end
    if (regRd && regAddr == ADDR_STAT && !dlab) begin
      s_nxt.pErr = 1'b0;
      s_nxt.fErr = 1'b0;
    end
    if (rxRdySet) begin
      s_nxt.rxRdy = 1'b1;
    end
    if (pErrSet) begin
      s_nxt.pErr = 1'b1;
    end
    if (fErrSet) begin
      s_nxt.fErr = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.line_format_control <= LCR_RST;
      s_r.modem_interface_control <= MCR_RST;
      s_r.divLo <= DIV_LO_RST;
      s_r.divHi <= DIV_HI_RST;
      s_r.efr <= EFR_RST;
      s_r.txLine <= 1'b1;
      s_r.out <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign regRdData = s_r.rdData;
  assign serialOut = s_r.out;
  assign enhancedCfg = s_r.efr;

  // ****************************************
  // checks
  // ****************************************
  logic [5:0] stopCnt;
  always_ff @(posedge core_clk) begin
    if (!rst_n || s_r.txSt != TX_STOP) begin
      stopCnt <= 6'h00;
    end else if (tick) begin
      stopCnt <= stopCnt + 6'h01;
    end
  end

  gate_read_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    regRd && regAddr == ADDR_DATA |=> regRdData
    == ($past(dlab) ? $past(s_r.divLo) : $past(s_r.rxData)))
    else $error("divisor gate read wrong");
  break_low_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_r.line_format_control[LCR_BRK] |=> !serialOut)
    else $error("break not held low");
  parity_bit_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_r.txSt == TX_PAR && $past(s_r.txSt) == TX_DATA
    |-> s_r.txLine == parBit(s_r.txByte, wlen, par))
    else $error("parity bit wrong");
  stop_len_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_r.txSt == TX_IDLE && $past(s_r.txSt) == TX_STOP
    |-> stopCnt == stopTicks(s_r.line_format_control[LCR_STOP], wlen))
    else $error("stop length wrong");
  word_len_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_r.txSt != TX_DATA && $past(s_r.txSt) == TX_DATA
    |-> $past(s_r.txBit) == {1'b0, wlen} + 3'h4)
    else $error("word length wrong");
  ir_pulse_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    irOn && !s_r.line_format_control[LCR_BRK] && s_r.txSt == TX_START && s_r.txTk == 6'h00
    |=> serialOut)
    else $error("no IR pulse for start bit");
  ir_idle_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    irOn && s_r.txSt == TX_IDLE |=> !serialOut)
    else $error("IR idle not low");
  std_idle_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !irOn && !s_r.line_format_control[LCR_BRK] && s_r.txSt == TX_IDLE
    && s_r.txLine |=> serialOut)
    else $error("standard idle not high");
  reset_clear_a: assert property (@(posedge core_clk)
    !rst_n |=> s_r.line_format_control == 8'h00 && !irOn)
    else $error("reset did not clear format");
  start_low_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_r.txSt == TX_START |-> !s_r.txLine)
    else $error("start bit not low");

  tx_frame_c: cover property (@(posedge core_clk) disable iff (!rst_n)
    s_r.txSt == TX_STOP ##1 s_r.txSt == TX_IDLE);
  rx_par_c: cover property (@(posedge core_clk) disable iff (!rst_n)
    rxRdySet && s_r.line_format_control[3]);
  ir_tx_c: cover property (@(posedge core_clk) disable iff (!rst_n)
    irOn && s_r.txSt == TX_DATA);
  ir_rx_c: cover property (@(posedge core_clk) disable iff (!rst_n)
    irOn && rxRdySet && !fErrSet);

endmodule
`default_nettype wire

// [dv/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ulfmc_pkg::*;
  localparam int LIMIT = 60000;
  localparam logic [2:0] PAR [5] = '{3'b110, 3'b001, 3'b011, 3'b101,
                                     3'b111};
  logic core_clk, rst_n, regWr, regRd, serialIn, serialOut, ok, prev;
  logic [2:0] regAddr;
  logic [7:0] regWrData, regRdData, enhancedCfg, s, d;
  logic [8:0] bits;
  int seed = 32'h3E96;
  int miscompares = 0;
  int nTests = 0;
  int cyc = 0;
  int cnt;

  ulfmc_top dut (
    .core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .serialIn(serialIn), .serialOut(serialOut),
    .enhancedCfg(enhancedCfg)
  );
  ulfmc_remote rx (
    .core_clk(core_clk), .txLine(serialOut), .rxLine(serialIn)
  );

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    nTests++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chkNear(input int got, input int exp, input int tol);
    nTests++;
    if (got > exp + tol || got < exp - tol) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic finishTest;
    $display("tests=%0d miscompares=%0d", nTests, miscompares);
    if (miscompares == 0 && nTests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic wrReg(input logic [2:0] a, input logic [7:0] v);
    regAddr <= a;
    regWrData <= v;
    regWr <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rdReg(input logic [2:0] a, output logic [7:0] v);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    @(posedge core_clk);
    v = regRdData;
  endtask

  function automatic logic expPar(input logic [7:0] v,
                                  input logic [2:0] p);
    case (p)
      3'b001: expPar = ~^v;
      3'b011: expPar = ^v;
      3'b101: expPar = 1'b1;
      default: expPar = 1'b0;
    endcase
  endfunction

  function automatic int stopCyc(input int bc, input logic [7:0] line_format_control);
    if (!line_format_control[2]) begin
      stopCyc = bc;
    end else begin
      stopCyc = (line_format_control[1:0] == 2'b00) ? bc * 3 / 2 : 2 * bc;
    end
  endfunction

  // one transmitted character, checked bit by bit and for length
  task automatic txCase(input logic [7:0] line_format_control, input int bc);
    int nb, sc, t0;
    logic [8:0] e;
    nb = 5 + line_format_control[1:0] + line_format_control[3];
    sc = stopCyc(bc, line_format_control);
    d = 8'($random(seed));
    e = {1'b0, d & (8'hFF >> (3 - line_format_control[1:0]))};
    if (line_format_control[3]) e[5 + line_format_control[1:0]] = expPar(e[7:0], line_format_control[5:3]);
    wrReg(ADDR_LCR, line_format_control);
    rdReg(ADDR_LCR, s);
    chk(s, line_format_control);
    wrReg(ADDR_DATA, d);
    t0 = cyc;
    rx.getChar(bc, nb, sc, bits, ok);
    chk(bits, e);
    chk(ok, 1'b1);
    s = 8'hFF;
    for (int n = 0; n < 100 && s[ST_TXBUSY]; n++) rdReg(ADDR_STAT, s);
    chkNear(cyc - t0, 3 + (1 + nb) * bc + sc, bc / 4 + 1);
  endtask

  task automatic rxCase(input logic [7:0] line_format_control, input logic bad);
    int nb;
    logic [8:0] e;
    nb = 5 + line_format_control[1:0] + line_format_control[3];
    d = 8'($random(seed)) & (8'hFF >> (3 - line_format_control[1:0]));
    e = {1'b0, d};
    if (line_format_control[3]) e[5 + line_format_control[1:0]] = expPar(d, line_format_control[5:3]) ^ bad;
    wrReg(ADDR_LCR, line_format_control);
    rx.putChar(16, nb, 16, e);
    s = 8'h00;
    for (int n = 0; n < 50 && !s[ST_RXRDY]; n++) rdReg(ADDR_STAT, s);
    chk(s[ST_PERR], bad);
    chk(s[ST_FERR], 1'b0);
    rdReg(ADDR_DATA, s);
    chk(s & (8'hFF >> (3 - line_format_control[1:0])), d);
  endtask

  // ****************************************
  // clock, timeout and main sequence
  // ****************************************
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      miscompares++;
      finishTest();
    end
  end

  initial begin
    rst_n = 1'b0;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = '0;
    regWrData = '0;
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    rdReg(ADDR_LCR, s);
    chk(s, LCR_RST);
    rdReg(ADDR_MCR, s);
    chk(s, MCR_RST);
    chk(serialOut, 1'b1);
    chk(enhancedCfg, EFR_RST);
    wrReg(ADDR_LCR, 8'h80);
    wrReg(ADDR_DATA, 8'h01);
    wrReg(ADDR_DIVHI, 8'h00);
    wrReg(ADDR_STAT, 8'hA5);
    rdReg(ADDR_STAT, s);
    chk(s, 8'hA5);
    chk(enhancedCfg, 8'hA5);
    chk(serialOut, 1'b1);
    wrReg(ADDR_LCR, 8'h00);
    wrReg(ADDR_STAT, 8'h5A);
    wrReg(3'h7, 8'hFF);
    rdReg(3'h7, s);
    chk(s, 8'h00);
    chk(enhancedCfg, 8'hA5);
    for (int i = 0; i < 20; i++) begin
      txCase({2'b00, PAR[i % 5], i >= 10, 2'(i)}, 16);
    end
    wrReg(ADDR_LCR, 8'h43);
    repeat (20) begin
      @(posedge core_clk);
      chk(serialOut, 1'b0);
    end
    wrReg(ADDR_LCR, 8'h03);
    repeat (2) @(posedge core_clk);
    chk(serialOut, 1'b1);
    wrReg(ADDR_MCR, 8'h80);
    txCase(8'h07, 64);
    wrReg(ADDR_MCR, 8'h00);
    for (int i = 0; i < 5; i++) begin
      rxCase({2'b00, PAR[i], 1'b0, 2'(i)}, i == 4);
    end
    wrReg(ADDR_LCR, 8'h03);
    wrReg(ADDR_MCR, 8'h40);
    rx.setIdle(1'b0);
    repeat (2) @(posedge core_clk);
    chk(serialOut, 1'b0);
    d = 8'($random(seed));
    wrReg(ADDR_DATA, d);
    cnt = 0;
    prev = 1'b0;
    repeat (200) begin
      @(posedge core_clk);
      cnt += (serialOut === 1'b1 && !prev);
      prev = (serialOut === 1'b1);
    end
    chk(16'(cnt), 16'(9 - $countones(d)));
    chk(serialOut, 1'b0);
    // drop whatever the mode switch left in the receiver
    rdReg(ADDR_DATA, s);
    rdReg(ADDR_STAT, s);
    d = 8'($random(seed));
    rx.putIr(8, {1'b0, d});
    rdReg(ADDR_STAT, s);
    chk(s[ST_RXRDY], 1'b1);
    chk(s[ST_FERR], 1'b0);
    rdReg(ADDR_DATA, s);
    chk(s, d);
    wrReg(ADDR_MCR, 8'h00);
    rx.setIdle(1'b1);
    repeat (2) @(posedge core_clk);
    chk(serialOut, 1'b1);
    finishTest();
  end
endmodule
`default_nettype wire

// [dv/ulfmc_remote.sv]
`timescale 1ns/1ps
`default_nettype none
module ulfmc_remote (
  input wire logic core_clk,
  input wire logic txLine,
  output logic rxLine
);
  initial rxLine = 1'b1;

  // ****************************************
  // line idle level and character tasks
  // ****************************************
  task automatic setIdle(input logic v);
    rxLine <= v;
  endtask

  task automatic getChar(input int bc, input int nb, input int sc,
                         output logic [8:0] bits, output logic ok);
    int n;
    bits = '0;
    n = 0;
    while (txLine === 1'b1 && n < 3000) begin
      @(posedge core_clk);
      n++;
    end
    repeat (bc / 2) @(posedge core_clk);
    ok = (txLine === 1'b0);
    for (int i = 0; i < nb; i++) begin
      repeat (bc) @(posedge core_clk);
      bits[i] = txLine;
    end
    repeat (bc / 2) @(posedge core_clk);
    for (int k = 0; k < sc - 3; k++) begin
      @(posedge core_clk);
      ok &= (txLine === 1'b1);
    end
  endtask

  task automatic putChar(input int bc, input int nb, input int sc,
                         input logic [8:0] bits);
    @(posedge core_clk);
    rxLine <= 1'b0;
    repeat (bc) @(posedge core_clk);
    for (int i = 0; i < nb; i++) begin
      rxLine <= bits[i];
      repeat (bc) @(posedge core_clk);
    end
    rxLine <= 1'b1;
    repeat (sc) @(posedge core_clk);
  endtask

  // ir character at 16 cycles a bit: short high pulse marks each zero
  task automatic putIr(input int nb, input logic [8:0] bits);
    logic [9:0] f;
    f = {bits, 1'b0};
    for (int i = 0; i <= nb; i++) begin
      @(posedge core_clk);
      rxLine <= !f[i];
      repeat (3) @(posedge core_clk);
      rxLine <= 1'b0;
      repeat (12) @(posedge core_clk);
    end
    repeat (32) @(posedge core_clk);
  endtask
endmodule
`default_nettype wire
